// *** verilog/reset_cause_pkg.sv ***
package reset_cause_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int PWRT_MS = 72;
   // Least time; any fraction of a cycle would be truncated.
   localparam int PWRT_CYCLES = ((CLK_HZ / 1000) * PWRT_MS + 0);
   localparam int OST_PERIODS = 1024;

   // ------------------------------------------------------------------
   // Register map (byte addresses) and field positions
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CAUSE = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_EVENT = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0C;
   localparam int CAUSE_BOR_BIT = 0;
   localparam int CAUSE_POR_BIT = 1;
   localparam int STATUS_PD_BIT = 3;
   localparam int STATUS_TO_BIT = 4;

   // Sticky event bits.
   localparam int EVT_POWERON = 0;
   localparam int EVT_BROWNOUT = 1;
   localparam int EVT_WDT_RESET = 2;
   localparam int EVT_WDT_WAKE = 3;
   localparam int EVT_EXT_RESET = 4;
   localparam int EVT_IRQ_WAKE = 5;
   localparam int EVT_W = 6;
   localparam logic [EVT_W-1:0] EVT_RESET = 6'h01;
   localparam logic [EVT_W-1:0] MASK_RESET = 6'h00;

   // ------------------------------------------------------------------
   // Program counter targets
   // ------------------------------------------------------------------
   localparam int PC_W = 13;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

   // All active low, as software sees them.
   typedef struct packed {
      logic timeout_n;
      logic powerdown_n;
      logic por_n;
      logic brownout_n;
   } cause_t;

   localparam cause_t FLAGS_RESET = '{timeout_n: 1'b1, powerdown_n: 1'b1,
                                      por_n: 1'b0, brownout_n: 1'b1};

   typedef enum logic [4:0] {
      S_RUN = 5'b00001,
      S_SLEEP = 5'b00010,
      S_PWRT = 5'b00100,
      S_OST = 5'b01000,
      S_PIN = 5'b10000
   } state_t;

endpackage : reset_cause_pkg

// *** verilog/reset_cause_and_startup_timing.sv ***
`timescale 1ns/100ps
// Functional notes
// - Brown-out flag bit 0, one after power-on.
// - Brown-out flag meaningless when detect is off.
// - Power-on flag bit 1, cleared only by power-on or a software write.
// - Crystal power-up waits 72 ms plus 1024 periods.
// - Brown-out, wake and RC delays per oscillator.
// - Cause flags encode power-on, brown-out, watchdog reset.
// - Timeout and power-down flags tell other events.
// - Resets load PC zero, wake-ups go PC+1.
// - Interrupt wake with global enable loads 0004h.
// - Resets initialise option, direction, timer-2 registers.
// - Any device reset makes port pins inputs.
// - Interrupt wake sets the waking source flags.
// - Power-down flag set at power-up, cleared by sleep.
// - Watchdog time-out clears the timeout flag.
module reset_cause_and_startup_timing
   import reset_cause_pkg::*;
#(
   parameter int PWRT_CYC = PWRT_CYCLES,
   parameter int OST_CNT = OST_PERIODS,
   parameter int ADDR_W = 8,
   parameter int SRC_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic en_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic brownout_detect_on_i,
   input wire logic powerup_timer_en_n_i,
   input wire logic osc_is_rc_i,
   input wire logic osc_tick_i,
   input wire logic brownout_i,
   input wire logic ext_reset_pin_n_i,
   input wire logic watchdog_timeout_i,
   input wire logic sleep_i,
   input wire logic wake_irq_i,
   input wire logic [SRC_W-1:0] wake_src_i,
   input wire logic global_irq_enable_i,
   input wire logic [PC_W-1:0] pc_i,
   output cause_t status_flags_o,
   output logic core_reset_o,
   output logic core_hold_o,
   output logic port_inputs_o,
   output logic pc_load_o,
   output logic [PC_W-1:0] pc_value_o,
   output logic irq_flag_set_o,
   output logic [SRC_W-1:0] irq_flag_src_o,
   output logic irq_o
);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (PWRT_CYC < 1 || OST_CNT < 1 || ADDR_W < 4 || ADDR_W > 32 ||
       SRC_W < 1) begin : g_bad_params
      $error("Unsupported parameter value.");
   end

   function automatic logic at_last(input logic [31:0] cnt,
                                    input int limit);
      return cnt == 32'(limit - 1);
   endfunction : at_last

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   state_t state_q, state_d;
   logic [31:0] cnt_q, cnt_d;
   logic need_ost_q, need_ost_d;
   logic rst_kind_q, rst_kind_d;
   logic boot_q;
   cause_t flags_q, flags_d;
   logic [EVT_W-1:0] evt_q, evt_set, evt_clr;
   logic [EVT_W-1:0] mask_q;
   logic [PC_W-1:0] wake_pc_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic core_reset_q, core_hold_q, pc_load_q, irq_set_q;
   logic [PC_W-1:0] pc_value_q;
   logic [SRC_W-1:0] irq_src_q;

   // ------------------------------------------------------------------
   // Event decode
   // ------------------------------------------------------------------
   // Brown-out beats the pin, which beats the watchdog and wake sources.
   wire is_run = (state_q == S_RUN);
   wire is_sleep = (state_q == S_SLEEP);
   wire pin_low = !ext_reset_pin_n_i;
   wire brown_ev = en_i && brownout_i && !boot_q;
   wire pin_ev = en_i && pin_low && !brownout_i && !boot_q &&
                 (is_run || is_sleep);
   wire quiet = !brownout_i && !pin_low && !boot_q;
   wire wdt_rst = en_i && quiet && watchdog_timeout_i && is_run;
   wire wdt_wake = en_i && quiet && watchdog_timeout_i && is_sleep;
   wire sleep_ev = en_i && quiet && !watchdog_timeout_i && sleep_i &&
                   is_run;
   wire irq_wake = en_i && quiet && !watchdog_timeout_i && wake_irq_i &&
                   is_sleep;
   wire wake_ev = wdt_wake || irq_wake;
   wire pwrt_done = (state_q == S_PWRT) && at_last(cnt_q, PWRT_CYC);
   wire ost_done = (state_q == S_OST) && osc_tick_i &&
                   at_last(cnt_q, OST_CNT);
   wire release_ev = en_i && !is_run && (state_d == S_RUN);
   wire hold_d = (state_d == S_PWRT) || (state_d == S_OST) ||
                 (state_d == S_PIN);

   // ------------------------------------------------------------------
   // Start-up sequencer
   // ------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      need_ost_d = need_ost_q;
      rst_kind_d = rst_kind_q;
      if (boot_q) begin
         // First cycle after power-on: choose delays from the options.
         rst_kind_d = 1'b1;
         need_ost_d = !osc_is_rc_i;
         cnt_d = 32'h0000_0000;
         if (!osc_is_rc_i && powerup_timer_en_n_i) begin
            state_d = S_OST;
         end else begin
            state_d = S_PWRT;
         end
      end else if (brown_ev) begin
         state_d = S_PWRT;
         need_ost_d = !osc_is_rc_i;
         rst_kind_d = 1'b1;
         cnt_d = 32'h0000_0000;
      end else if (pin_ev) begin
         state_d = S_PIN;
         rst_kind_d = 1'b1;
      end else if (wake_ev) begin
         rst_kind_d = 1'b0;
         cnt_d = 32'h0000_0000;
         // RC wake-up resumes at once; a crystal needs its count.
         state_d = osc_is_rc_i ? S_RUN : S_OST;
      end else if (sleep_ev) begin
         state_d = S_SLEEP;
      end else begin
         case (state_q)
            S_PWRT: begin
               cnt_d = cnt_q + 32'h0000_0001;
               if (pwrt_done) begin
                  cnt_d = 32'h0000_0000;
                  state_d = need_ost_q ? S_OST : S_RUN;
               end
            end
            S_OST: begin
               if (osc_tick_i) begin
                  cnt_d = cnt_q + 32'h0000_0001;
               end
               if (ost_done) begin
                  cnt_d = 32'h0000_0000;
                  state_d = S_RUN;
               end
            end
            S_PIN: begin
               if (!pin_low) begin
                  state_d = S_RUN;
               end
            end
            S_RUN, S_SLEEP: begin
               state_d = state_q;
            end
            default: begin
               state_d = S_PWRT;
               cnt_d = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= S_PWRT;
         cnt_q <= 32'h0000_0000;
         need_ost_q <= 1'b0;
         rst_kind_q <= 1'b1;
         boot_q <= 1'b1;
      end else if (en_i) begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         need_ost_q <= need_ost_d;
         rst_kind_q <= rst_kind_d;
         boot_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Core-facing outputs
   // ------------------------------------------------------------------
   // Crystal wake-up holds the core; no wake-up is a reset, so its registers keep.
   wire [PC_W-1:0] wake_target = global_irq_enable_i && irq_wake ?
                                 IRQ_VECTOR : pc_i + 13'h0001;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         core_reset_q <= 1'b1;
         core_hold_q <= 1'b1;
         pc_load_q <= 1'b0;
         pc_value_q <= PC_RESET;
         wake_pc_q <= PC_RESET;
         irq_set_q <= 1'b0;
         irq_src_q <= '0;
      end else if (en_i) begin
         core_reset_q <= (hold_d && rst_kind_d) || wdt_rst;
         core_hold_q <= hold_d || (state_d == S_SLEEP);
         pc_load_q <= release_ev || wdt_rst;
         if (wake_ev) begin
            wake_pc_q <= wake_target;
         end
         if (wdt_rst || rst_kind_d) begin
            pc_value_q <= PC_RESET;
         end else if (wake_ev) begin
            pc_value_q <= wake_target;
         end else begin
            pc_value_q <= wake_pc_q;
         end
         irq_set_q <= irq_wake;
         if (irq_wake) begin
            irq_src_q <= wake_src_i;
         end
      end
   end

   assign core_reset_o = core_reset_q;
   assign core_hold_o = core_hold_q;
   assign port_inputs_o = core_reset_q;
   assign pc_load_o = pc_load_q;
   assign pc_value_o = pc_value_q;
   assign irq_flag_set_o = irq_set_q;
   assign irq_flag_src_o = irq_src_q;

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   wire setup = psel_i && !penable_i;
   wire access_wr = en_i && psel_i && penable_i && pwrite_i;
   wire hit_cause = (paddr_i == ADDR_W'(ADDR_CAUSE));
   wire hit_status = (paddr_i == ADDR_W'(ADDR_STATUS));
   wire hit_event = (paddr_i == ADDR_W'(ADDR_EVENT));
   wire hit_mask = (paddr_i == ADDR_W'(ADDR_MASK));
   wire hit_any = hit_cause || hit_status || hit_event || hit_mask;
   wire cause_wr = access_wr && hit_cause;
   wire [31:0] rd_cause = 32'({flags_q.por_n, flags_q.brownout_n});
   wire [31:0] rd_status = 32'({flags_q.timeout_n, flags_q.powerdown_n})
                           << STATUS_PD_BIT;
   wire [31:0] rdata_mux = hit_cause ? rd_cause :
                           hit_status ? rd_status :
                           hit_event ? 32'(evt_q) :
                           hit_mask ? 32'(mask_q) : 32'h0000_0000;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (en_i && setup) begin
         prdata_q <= pwrite_i ? 32'h0000_0000 : rdata_mux;
         pslverr_q <= !hit_any;
      end
   end

   assign pready_o = en_i;
   assign prdata_o = prdata_q;
   assign pslverr_o = pslverr_q;

   // ------------------------------------------------------------------
   // Reset-cause flags
   // ------------------------------------------------------------------
   // Software may set or clear the two cause bits; a hardware event in
   // the same cycle overrides the write. The brown-out bit is kept as
   // written when detection is off, so it is not meaningful then.
   always_comb begin
      flags_d = flags_q;
      if (cause_wr) begin
         flags_d.por_n = pwdata_i[CAUSE_POR_BIT];
         flags_d.brownout_n = pwdata_i[CAUSE_BOR_BIT];
      end
      if (brown_ev && brownout_detect_on_i) begin
         flags_d.brownout_n = 1'b0;
      end
      if (brown_ev) begin
         flags_d.timeout_n = 1'b1;
         flags_d.powerdown_n = 1'b1;
      end
      if (pin_ev && is_sleep) begin
         flags_d.timeout_n = 1'b1;
         flags_d.powerdown_n = 1'b0;
      end
      if (wdt_rst || wdt_wake) begin
         flags_d.timeout_n = 1'b0;
         flags_d.powerdown_n = is_run;
      end
      if (sleep_ev || irq_wake) begin
         flags_d.timeout_n = 1'b1;
         flags_d.powerdown_n = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flags_q <= FLAGS_RESET;
      end else if (en_i) begin
         flags_q <= flags_d;
      end
   end

   assign status_flags_o = flags_q;

   // ------------------------------------------------------------------
   // Event status, mask and interrupt
   // ------------------------------------------------------------------
   always_comb begin
      evt_set = '0;
      evt_set[EVT_BROWNOUT] = brown_ev;
      evt_set[EVT_WDT_RESET] = wdt_rst;
      evt_set[EVT_WDT_WAKE] = wdt_wake;
      evt_set[EVT_EXT_RESET] = pin_ev;
      evt_set[EVT_IRQ_WAKE] = irq_wake;
   end

   assign evt_clr = (access_wr && hit_event) ? pwdata_i[EVT_W-1:0] : '0;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_q <= EVT_RESET;
         mask_q <= MASK_RESET;
      end else if (en_i) begin
         evt_q <= (evt_q & ~evt_clr) | evt_set;
         if (access_wr && hit_mask) begin
            mask_q <= pwdata_i[EVT_W-1:0];
         end
      end
   end

   assign irq_o = |(evt_q & mask_q);

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   sequence s_pwrt_end;
      (state_q == S_PWRT) && pwrt_done && en_i && !brown_ev;
   endsequence

   property p_por_only_sw;
      @(posedge clk_i) disable iff (!rst_n_i)
      !$past(cause_wr) && !$past(boot_q) |-> $stable(flags_q.por_n);
   endproperty
   a_por_only_sw: assert property (p_por_only_sw)
      else $error("Power-on flag changed without a write.");

   property p_brown_flags;
      @(posedge clk_i) disable iff (!rst_n_i)
      brown_ev && brownout_detect_on_i |=> !flags_q.brownout_n &&
         flags_q.timeout_n && flags_q.powerdown_n && core_reset_o;
   endproperty
   a_brown_flags: assert property (p_brown_flags)
      else $error("Brown-out did not set its flags or reset.");

   property p_pwrt_count;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_pwrt_end |=> (state_q == (need_ost_q ? S_OST : S_RUN)) &&
         (cnt_q == 32'h0000_0000);
   endproperty
   a_pwrt_count: assert property (p_pwrt_count)
      else $error("Fixed delay did not hand over correctly.");

   property p_ost_count;
      @(posedge clk_i) disable iff (!rst_n_i)
      en_i && (state_q == S_OST) && (state_d == S_RUN) && !boot_q &&
         !brown_ev |-> osc_tick_i && at_last(cnt_q, OST_CNT);
   endproperty
   a_ost_count: assert property (p_ost_count)
      else $error("Oscillator count ended early.");

   property p_wdt_flag;
      @(posedge clk_i) disable iff (!rst_n_i)
      wdt_rst or wdt_wake |=> !flags_q.timeout_n;
   endproperty
   a_wdt_flag: assert property (p_wdt_flag)
      else $error("Watchdog did not clear the timeout flag.");

   property p_sleep_flag;
      @(posedge clk_i) disable iff (!rst_n_i)
      sleep_ev |=> !flags_q.powerdown_n && flags_q.timeout_n &&
         (state_q == S_SLEEP);
   endproperty
   a_sleep_flag: assert property (p_sleep_flag)
      else $error("Sleep did not clear the power-down flag.");

   property p_irq_vector;
      @(posedge clk_i) disable iff (!rst_n_i)
      irq_wake && global_irq_enable_i |=> wake_pc_q == IRQ_VECTOR;
   endproperty
   a_irq_vector: assert property (p_irq_vector)
      else $error("Interrupt wake did not target the vector.");

   property p_wake_keeps;
      @(posedge clk_i) disable iff (!rst_n_i)
      wake_ev |=> !core_reset_o && core_hold_o == !osc_is_rc_i;
   endproperty
   a_wake_keeps: assert property (p_wake_keeps)
      else $error("Wake-up reset the core registers.");

   property p_irq_src;
      @(posedge clk_i) disable iff (!rst_n_i)
      irq_wake |=> irq_flag_set_o && irq_flag_src_o == $past(wake_src_i);
   endproperty
   a_irq_src: assert property (p_irq_src)
      else $error("Waking source flags not raised.");

endmodule : reset_cause_and_startup_timing

// *** verilog/unused_placeholder_none.sv ***
`timescale 1ns/100ps

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   import reset_cause_pkg::*;
   // ------------------------------------------------------------------
   // Bench set-up
   // ------------------------------------------------------------------
   // Short counts keep each start-up delay to a few dozen cycles.
   localparam int PW = 20;
   localparam int OC = 4;
   localparam logic [31:0] ONE = 32'h0000_0001;
   localparam logic [31:0] Z = 32'h0000_0000;
   localparam logic [30:0] Z31 = 31'h0000_0000;
   logic clk_i, rst_n_i, en_i, psel_i, penable_i, pwrite_i, pready_o;
   logic pslverr_o, brownout_detect_on_i, powerup_timer_en_n_i;
   logic osc_is_rc_i, osc_tick_i, brownout_i, ext_reset_pin_n_i;
   logic watchdog_timeout_i, sleep_i, wake_irq_i, global_irq_enable_i;
   logic core_reset_o, core_hold_o, port_inputs_o, pc_load_o;
   logic irq_flag_set_o, irq_o, w_rst, w_irq, er;
   logic [7:0] paddr_i, wake_src_i, irq_flag_src_o, w_src;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [PC_W-1:0] pc_i, pc_value_o, w_pc;
   cause_t status_flags_o;
   int mismatches, n_compared, w_n;

   reset_cause_and_startup_timing #(.PWRT_CYC(PW), .OST_CNT(OC)) uut (
      .clk_i, .rst_n_i, .en_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .brownout_detect_on_i,
      .powerup_timer_en_n_i, .osc_is_rc_i, .osc_tick_i, .brownout_i,
      .ext_reset_pin_n_i, .watchdog_timeout_i, .sleep_i, .wake_irq_i,
      .wake_src_i, .global_irq_enable_i, .pc_i, .status_flags_o,
      .core_reset_o, .core_hold_o, .port_inputs_o, .pc_load_o, .pc_value_o,
      .irq_flag_set_o, .irq_flag_src_o, .irq_o
   );

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // The oscillator ticks every other cycle, so the period count is slower
   // than the system clock, as it would be on a real part.
   initial begin
      osc_tick_i = 1'b0;
      forever begin
         @(posedge clk_i);
         osc_tick_i <= ~osc_tick_i;
      end
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask : chk

   task automatic fail_wait();
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      mismatches++;
      stop_test();
   endtask : fail_wait

   task automatic chk_st(input logic [3:0] exp);
      @(negedge clk_i);
      chk({28'h000_0000, status_flags_o}, {28'h000_0000, exp});
      @(posedge clk_i);
   endtask : chk_st

   task automatic out_is(input int k, input logic e);
      logic b;
      @(negedge clk_i);
      b = (k == 0) ? irq_o : (k == 1) ? core_hold_o : port_inputs_o;
      chk({Z31, b}, {Z31, e});
      @(posedge clk_i);
   endtask : out_is

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (pready_o !== 1'b1) fail_wait();
      @(posedge clk_i);
   endtask : apb

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                      input logic e);
      apb(1'b0, a, Z);
      chk(rd, exp);
      chk({Z31, er}, {Z31, e});
   endtask : rdc

   task automatic pulse(input int k);
      case (k)
         0: watchdog_timeout_i <= 1'b1;
         1: sleep_i <= 1'b1;
         2: wake_irq_i <= 1'b1;
         default: brownout_i <= 1'b1;
      endcase
      @(posedge clk_i);
      watchdog_timeout_i <= 1'b0;
      sleep_i <= 1'b0;
      wake_irq_i <= 1'b0;
      brownout_i <= 1'b0;
   endtask : pulse

   task automatic wait_pc(input int lim);
      w_n = 0;
      w_rst = 1'b0;
      w_irq = 1'b0;
      do begin
         @(negedge clk_i);
         w_n++;
         if (core_reset_o === 1'b1) w_rst = 1'b1;
         if (irq_flag_set_o === 1'b1) begin
            w_irq = 1'b1;
            w_src = irq_flag_src_o;
         end
      end while (pc_load_o !== 1'b1 && w_n < lim);
      w_pc = pc_value_o;
      if (pc_load_o !== 1'b1) fail_wait();
      @(posedge clk_i);
   endtask : wait_pc

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic sc_power_on();
      out_is(2, 1'b1);
      rst_n_i <= 1'b1;
      wait_pc(100);
      chk(32'(w_n >= PW + OC && w_n <= PW + 3 * OC + 6), ONE);
      chk(32'(w_pc), Z);
      chk_st(4'b1101);
      rdc(ADDR_CAUSE, ONE, 1'b0);
      rdc(ADDR_STATUS, 32'h0000_0018, 1'b0);
      rdc(ADDR_EVENT, ONE, 1'b0);
      apb(1'b1, ADDR_CAUSE, 32'h0000_0003);
      rdc(ADDR_CAUSE, 32'h0000_0003, 1'b0);
   endtask : sc_power_on

   task automatic sc_ost_only();
      rst_n_i <= 1'b0;
      powerup_timer_en_n_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wait_pc(100);
      chk(32'(w_n < PW && w_n >= OC), ONE);
      rdc(ADDR_CAUSE, ONE, 1'b0);
      apb(1'b1, ADDR_CAUSE, 32'h0000_0003);
   endtask : sc_ost_only

   task automatic sc_wdt_reset();
      apb(1'b1, ADDR_EVENT, 32'h0000_003F);
      rdc(ADDR_EVENT, Z, 1'b0);
      apb(1'b1, ADDR_MASK, 32'h0000_0004);
      pulse(0);
      wait_pc(10);
      chk(32'(w_pc), Z);
      chk({Z31, w_rst}, ONE);
      chk_st(4'b0111);
      out_is(0, 1'b1);
      rdc(ADDR_EVENT, 32'h0000_0004, 1'b0);
      rdc(ADDR_MASK, 32'h0000_0004, 1'b0);
      apb(1'b1, ADDR_EVENT, 32'h0000_0004);
      out_is(0, 1'b0);
      apb(1'b1, ADDR_MASK, Z);
      pulse(0);
      wait_pc(10);
      out_is(0, 1'b0);
      apb(1'b1, ADDR_MASK, 32'h0000_0004);
      out_is(0, 1'b1);
      apb(1'b1, ADDR_EVENT, 32'h0000_003F);
      out_is(0, 1'b0);
      apb(1'b1, ADDR_STATUS, 32'h0000_0018);
      rdc(ADDR_STATUS, 32'h0000_0008, 1'b0);
      rdc(8'h10, Z, 1'b1);
   endtask : sc_wdt_reset

   task automatic sc_wake(input logic global_irq_enable, input logic rc,
                          input logic [PC_W-1:0] exp);
      osc_is_rc_i <= rc;
      global_irq_enable_i <= global_irq_enable;
      pc_i <= 13'h0123;
      wake_src_i <= 8'h05;
      pulse(1);
      chk_st(4'b1011);
      out_is(1, 1'b1);
      pulse(2);
      wait_pc(40);
      chk(32'(w_pc), 32'(exp));
      chk({Z31, w_irq}, ONE);
      chk({24'h00_0000, w_src}, 32'h0000_0005);
      chk({Z31, w_rst}, Z);
      chk(32'(rc ? w_n <= 3 : w_n >= OC), ONE);
      chk_st(4'b1011);
   endtask : sc_wake

   task automatic sc_wdt_wake_and_pin();
      osc_is_rc_i <= 1'b0;
      pc_i <= 13'h0200;
      pulse(1);
      chk_st(4'b1011);
      pulse(0);
      wait_pc(40);
      chk(32'(w_pc), 32'h0000_0201);
      chk({Z31, w_rst}, Z);
      chk_st(4'b0011);
      ext_reset_pin_n_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      out_is(2, 1'b1);
      ext_reset_pin_n_i <= 1'b1;
      wait_pc(10);
      chk(32'(w_pc), Z);
      chk_st(4'b0011);
      pulse(1);
      chk_st(4'b1011);
      ext_reset_pin_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      ext_reset_pin_n_i <= 1'b1;
      wait_pc(10);
      chk(32'(w_pc), Z);
      chk_st(4'b1011);
   endtask : sc_wdt_wake_and_pin

   // With the clock enable low a watchdog time-out must not reach the
   // flags, and the bus must not answer.
   task automatic sc_freeze();
      en_i <= 1'b0;
      pulse(0);
      @(negedge clk_i);
      chk({Z31, pready_o}, Z);
      chk_st(4'b1011);
      en_i <= 1'b1;
   endtask : sc_freeze

   task automatic sc_brownout();
      pulse(3);
      wait_pc(100);
      chk(32'(w_n >= PW + OC), ONE);
      chk(32'(w_pc), Z);
      chk_st(4'b1110);
      rdc(ADDR_CAUSE, 32'h0000_0002, 1'b0);
      brownout_detect_on_i <= 1'b0;
      osc_is_rc_i <= 1'b1;
      apb(1'b1, ADDR_CAUSE, 32'h0000_0003);
      pulse(3);
      wait_pc(100);
      chk(32'(w_n >= PW && w_n <= PW + 3), ONE);
      rdc(ADDR_CAUSE, 32'h0000_0003, 1'b0);
   endtask : sc_brownout

   initial begin
      mismatches = 0;
      n_compared = 0;
      rst_n_i = 1'b0;
      en_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = Z;
      brownout_detect_on_i = 1'b1;
      powerup_timer_en_n_i = 1'b0;
      osc_is_rc_i = 1'b0;
      brownout_i = 1'b0;
      ext_reset_pin_n_i = 1'b1;
      watchdog_timeout_i = 1'b0;
      sleep_i = 1'b0;
      wake_irq_i = 1'b0;
      wake_src_i = 8'h00;
      global_irq_enable_i = 1'b0;
      pc_i = 13'h0000;
      repeat (9) @(posedge clk_i);
      sc_power_on();
      sc_ost_only();
      sc_wdt_reset();
      sc_wake(1'b1, 1'b0, 13'h0004);
      sc_wake(1'b0, 1'b0, 13'h0124);
      sc_wake(1'b1, 1'b1, 13'h0004);
      sc_wdt_wake_and_pin();
      sc_freeze();
      sc_brownout();
      stop_test();
   end
endmodule : tb_top
